/* File: eeprom_rtc_serial_slave.sv */
// Purpose: Two-wire slave front end for memory array and clock area
// Assumes: Bus pins are asynchronous; SCL at most 400 kHz
// Notes:   Data writes are buffered and committed after a valid stop
`timescale 1ns/1ps
`default_nettype none
module eeprom_rtc_serial_slave #(
  parameter int WRITE_CYCLES = serial_slave_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Two-wire bus pins
  input  wire logic scl,
  input  wire logic sdaIn,
  output var  logic sdaOut,
  output var  logic sdaOe,
  // Configuration and status
  input  wire logic arrayProtect,
  output var  logic writeBusy,
  output var  logic writeEnableLatch,
  output var  logic registerWriteLatch
);

  serial_slave_pkg::state_t state_reg;

  logic        sclLvl;
  logic        sclPrev;
  logic        sdaLvl;
  logic        sclRise;
  logic        sclFall;
  logic        sdaRise;
  logic        sdaFall;
  logic        startSeen;
  logic        stopSeen;
  logic        byteTake;
  logic        loadRead;
  logic        validStop;
  logic        statusTarget;
  logic        slaveHit;
  logic        ackDecide;
  logic        protectedWr;
  logic [7:0]  readData;
  logic [3:0]  bitCnt_reg;
  logic [7:0]  shift_reg;
  logic [1:0]  byteIdx_reg;
  logic        isRead_reg;
  logic        isArea_reg;
  logic        masterAck_reg;
  logic [7:0]  addrHi_reg;
  logic [15:0] addrCnt_reg;
  logic        statusWr_reg;
  logic [7:0]  statusVal_reg;
  logic        haveData_reg;
  logic [63:0] bufValid_reg;
  logic        busy_reg;
  logic [23:0] timer_reg;
  logic [6:0]  commitIdx_reg;
  logic        commitArea_reg;
  logic [15:0] commitBase_reg;
  logic        wrEn_reg;
  logic        regEn_reg;
  logic        sdaOe_reg;
  logic        sdaOut_reg;
  logic [7:0]  bufData [serial_slave_pkg::PAGE_BYTES];
  logic [7:0]  arrayMem [serial_slave_pkg::ARRAY_DEPTH];
  logic [7:0]  areaMem [serial_slave_pkg::AREA_DEPTH];

  // ----------------------------------------------------------------
  // Address arithmetic
  // ----------------------------------------------------------------
  function automatic logic [15:0] pageInc(input logic [15:0] a,
                                          input logic        area);
    logic [15:0] r;
    r = a;
    if (area) begin
      r[2:0] = a[2:0] + 3'h1;
    end else begin
      r[5:0] = a[5:0] + 6'h01;
    end
    return r;
  endfunction

  function automatic logic [15:0] seqInc(input logic [15:0] a,
                                         input logic        area);
    logic [15:0] r;
    r = 16'h0000;
    if (area) begin
      r[5:0] = a[5:0] + 6'h01;
    end else begin
      r[8:0] = a[8:0] + 9'h001;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation and bus conditions
  // ----------------------------------------------------------------
  two_wire_sync pinSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .scl     (scl),
    .sdaIn   (sdaIn),
    .sclLvl  (sclLvl),
    .sclPrev (sclPrev),
    .sdaLvl  (sdaLvl),
    .sclRise (sclRise),
    .sclFall (sclFall),
    .sdaRise (sdaRise),
    .sdaFall (sdaFall)
  );

  always_comb begin
    startSeen = sdaFall & sclLvl & sclPrev;
    stopSeen  = sdaRise & sclLvl & sclPrev;
    byteTake  = (state_reg == serial_slave_pkg::ST_RX) & sclFall &
                (bitCnt_reg == serial_slave_pkg::BYTE_BITS);
    loadRead  = sclFall & sdaOe_reg & isRead_reg &
                (state_reg == serial_slave_pkg::ST_RXACK) |
                sclFall & masterAck_reg &
                (state_reg == serial_slave_pkg::ST_TXACK);
  end

  // ----------------------------------------------------------------
  // Byte decisions
  // ----------------------------------------------------------------
  always_comb begin
    slaveHit = (shift_reg[7:1] == serial_slave_pkg::ARRAY_SLAVE) ||
               (shift_reg[7:1] == serial_slave_pkg::AREA_SLAVE);
    statusTarget = isArea_reg &&
                   (addrCnt_reg == serial_slave_pkg::STATUS_ADDR);
    protectedWr  = isArea_reg ? ~regEn_reg : arrayProtect;
    unique case (byteIdx_reg)
      2'h0: ackDecide = slaveHit & ~busy_reg;
      2'h1: ackDecide = 1'b1;
      2'h2: ackDecide = 1'b1;
      default: ackDecide = statusTarget ? ~statusWr_reg : wrEn_reg;
    endcase
    // A stop just after an acked byte arrives one SCL rise into the next
    validStop = stopSeen & (state_reg == serial_slave_pkg::ST_RX) &
                (bitCnt_reg <= 4'h1) & haveData_reg & ~isRead_reg;
  end

  always_comb begin
    if (isArea_reg) begin
      if (addrCnt_reg == serial_slave_pkg::STATUS_ADDR) begin
        readData = {5'h00, regEn_reg, wrEn_reg, 1'b0};
      end else begin
        readData = areaMem[addrCnt_reg[5:0]];
      end
    end else begin
      readData = arrayMem[addrCnt_reg[8:0]];
    end
  end

  // ----------------------------------------------------------------
  // Protocol sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= serial_slave_pkg::ST_IDLE;
      bitCnt_reg <= 4'h0;
    end else if (stopSeen) begin
      state_reg  <= serial_slave_pkg::ST_IDLE;
      bitCnt_reg <= 4'h0;
    end else if (startSeen) begin
      state_reg  <= serial_slave_pkg::ST_RX;
      bitCnt_reg <= 4'h0;
    end else begin
      unique case (state_reg)
        serial_slave_pkg::ST_IDLE: begin
          bitCnt_reg <= 4'h0;
        end
        serial_slave_pkg::ST_RX: begin
          if (sclRise) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (byteTake) begin
            state_reg <= serial_slave_pkg::ST_RXACK;
          end
        end
        serial_slave_pkg::ST_RXACK: begin
          if (sclFall) begin
            if (!sdaOe_reg) begin
              state_reg <= serial_slave_pkg::ST_IDLE;
            end else if (isRead_reg) begin
              state_reg  <= serial_slave_pkg::ST_TX;
              bitCnt_reg <= 4'h1;
            end else begin
              state_reg  <= serial_slave_pkg::ST_RX;
              bitCnt_reg <= 4'h0;
            end
          end
        end
        serial_slave_pkg::ST_TX: begin
          if (sclFall) begin
            if (bitCnt_reg == serial_slave_pkg::BYTE_BITS) begin
              state_reg <= serial_slave_pkg::ST_TXACK;
            end else begin
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        end
        serial_slave_pkg::ST_TXACK: begin
          if (sclFall) begin
            if (masterAck_reg) begin
              state_reg  <= serial_slave_pkg::ST_TX;
              bitCnt_reg <= 4'h1;
            end else begin
              state_reg <= serial_slave_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Shift register serves both directions
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
    end else if (loadRead) begin
      shift_reg <= readData;
    end else if (state_reg == serial_slave_pkg::ST_RX && sclRise) begin
      shift_reg <= {shift_reg[6:0], sdaLvl};
    end else if (state_reg == serial_slave_pkg::ST_TX && sclFall) begin
      shift_reg <= {shift_reg[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      masterAck_reg <= 1'b0;
    end else if (state_reg == serial_slave_pkg::ST_TXACK && sclRise) begin
      masterAck_reg <= ~sdaLvl;
    end else if (state_reg != serial_slave_pkg::ST_TXACK) begin
      masterAck_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // SDA drive; only ever pulls low
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdaOe_reg  <= 1'b0;
      sdaOut_reg <= 1'b0;
    end else if (stopSeen || startSeen) begin
      sdaOe_reg <= 1'b0;
    end else if (byteTake) begin
      sdaOe_reg <= ackDecide;
    end else if (loadRead) begin
      sdaOe_reg <= ~readData[7];
    end else if (sclFall) begin
      if (state_reg == serial_slave_pkg::ST_TX &&
          bitCnt_reg != serial_slave_pkg::BYTE_BITS) begin
        sdaOe_reg <= ~shift_reg[6];
      end else begin
        sdaOe_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byteIdx_reg <= 2'h0;
      isRead_reg  <= 1'b0;
      isArea_reg  <= 1'b0;
      addrHi_reg  <= 8'h00;
    end else if (startSeen) begin
      byteIdx_reg <= 2'h0;
    end else if (byteTake) begin
      if (byteIdx_reg != serial_slave_pkg::IDX_DATA) begin
        byteIdx_reg <= byteIdx_reg + 2'h1;
      end
      if (byteIdx_reg == 2'h0) begin
        isRead_reg <= shift_reg[0];
        isArea_reg <= shift_reg[7:4] == serial_slave_pkg::AREA_ID;
      end
      if (byteIdx_reg == 2'h1) begin
        addrHi_reg <= shift_reg;
      end
    end
  end

  // Counter: word address load, page step, sequential step
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addrCnt_reg <= serial_slave_pkg::ADDR_RESET;
    end else if (byteTake && byteIdx_reg == 2'h2) begin
      addrCnt_reg <= {addrHi_reg, shift_reg};
    end else if (byteTake && ackDecide && !statusTarget &&
                 byteIdx_reg == serial_slave_pkg::IDX_DATA) begin
      addrCnt_reg <= pageInc(addrCnt_reg, isArea_reg);
    end else if (loadRead) begin
      addrCnt_reg <= seqInc(addrCnt_reg, isArea_reg);
    end
  end

  // ----------------------------------------------------------------
  // Page buffer; memory untouched until a valid stop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bufValid_reg  <= 64'h0;
      haveData_reg  <= 1'b0;
      statusWr_reg  <= 1'b0;
      statusVal_reg <= 8'h00;
    end else if (byteTake && byteIdx_reg == 2'h0) begin
      bufValid_reg <= 64'h0;
      haveData_reg <= 1'b0;
      statusWr_reg <= 1'b0;
    end else if (byteTake && ackDecide &&
                 byteIdx_reg == serial_slave_pkg::IDX_DATA) begin
      haveData_reg <= 1'b1;
      if (statusTarget) begin
        statusWr_reg  <= 1'b1;
        statusVal_reg <= shift_reg;
      end else begin
        bufValid_reg[addrCnt_reg[5:0]] <= 1'b1;
      end
    end
  end

  // Later bytes to the same slot simply overwrite earlier ones
  always_ff @(posedge sys_clk) begin
    if (byteTake && ackDecide && !statusTarget &&
        byteIdx_reg == serial_slave_pkg::IDX_DATA) begin
      bufData[addrCnt_reg[5:0]] <= shift_reg;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg       <= 1'b0;
      timer_reg      <= 24'h0;
      commitIdx_reg  <= serial_slave_pkg::PAGE_END;
      commitArea_reg <= 1'b0;
      commitBase_reg <= serial_slave_pkg::ADDR_RESET;
    end else if (busy_reg) begin
      if (timer_reg != 24'h0) begin
        timer_reg <= timer_reg - 24'h1;
      end
      if (commitIdx_reg != serial_slave_pkg::PAGE_END) begin
        commitIdx_reg <= commitIdx_reg + 7'h1;
      end else if (timer_reg == 24'h0) begin
        busy_reg <= 1'b0;
      end
    end else if (validStop && !statusWr_reg && !protectedWr) begin
      busy_reg       <= 1'b1;
      timer_reg      <= 24'(WRITE_CYCLES);
      commitIdx_reg  <= 7'h0;
      commitArea_reg <= isArea_reg;
      commitBase_reg <= addrCnt_reg;
    end
  end

  // Storage is not reset; contents are undefined until written
  always_ff @(posedge sys_clk) begin
    if (busy_reg && commitIdx_reg != serial_slave_pkg::PAGE_END &&
        bufValid_reg[commitIdx_reg[5:0]]) begin
      if (commitArea_reg) begin
        areaMem[{commitBase_reg[5:3], commitIdx_reg[2:0]}] <=
          bufData[commitIdx_reg[5:0]];
      end else begin
        arrayMem[{commitBase_reg[8:6], commitIdx_reg[5:0]}] <=
          bufData[commitIdx_reg[5:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // Write enable latches
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrEn_reg  <= 1'b0;
      regEn_reg <= 1'b0;
    end else if (validStop && statusWr_reg) begin
      wrEn_reg  <= statusVal_reg[serial_slave_pkg::WR_EN_BIT];
      regEn_reg <= statusVal_reg[serial_slave_pkg::REG_EN_BIT];
    end else if (busy_reg && timer_reg == 24'h0 &&
                 commitIdx_reg == serial_slave_pkg::PAGE_END) begin
      regEn_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sdaOut             = sdaOut_reg;
  assign sdaOe              = sdaOe_reg;
  assign writeBusy          = busy_reg;
  assign writeEnableLatch   = wrEn_reg;
  assign registerWriteLatch = regEn_reg;

endmodule
`default_nettype wire

/* File: eeprom_rtc_serial_slave_assertions.sv */
// Purpose: Pin-level checks of the two-wire slave
// Assumes: Raw pins, sampled on sys_clk
// Notes:   Bound into every slave instance
`timescale 1ns/1ps
`default_nettype none
module slave_checker #(
  parameter int WRITE_CYCLES = 100
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Configuration and status
  input wire logic arrayProtect,
  input wire logic writeBusy,
  input wire logic writeEnableLatch,
  input wire logic registerWriteLatch
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Helper
  // ----------------------------------------------------------------
  int busyCnt_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) busyCnt_reg <= 0;
    else if (writeBusy) busyCnt_reg <= busyCnt_reg + 1;
    else busyCnt_reg <= 0;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_drive_low; sdaOe |-> !sdaOut; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("sda driven high");
  property p_ack_stands; $rose(scl) && sdaOe |-> sdaOe [*3]; endproperty
  a_ack_stands: assert property (p_ack_stands)
    else $error("sda drive moved while scl high");
  property p_change_low; $changed(sdaOe) |-> !scl; endproperty
  a_change_low: assert property (p_change_low)
    else $error("sda drive changed with scl high");
  property p_busy_quiet; writeBusy |-> !sdaOe; endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("sda driven while busy");
  property p_busy_len; $fell(writeBusy) |-> busyCnt_reg >= WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle too short");
  property p_busy_idle; $rose(writeBusy) |-> scl && sdaIn; endproperty
  a_busy_idle: assert property (p_busy_idle)
    else $error("write cycle began off a stop");
  property p_wel_stop; $changed(writeEnableLatch) |-> scl && sdaIn;
  endproperty
  a_wel_stop: assert property (p_wel_stop)
    else $error("latch moved away from a stop");
  property p_protect;
    arrayProtect && !registerWriteLatch |-> !$rose(writeBusy);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protected write started a cycle");
  property p_register_write_latch_drop;
    $fell(writeBusy) |-> ##[0:2] !registerWriteLatch;
  endproperty
  a_register_write_latch_drop: assert property (p_register_write_latch_drop)
    else $error("register latch kept after write");
endmodule
bind eeprom_rtc_serial_slave slave_checker #(
  .WRITE_CYCLES(WRITE_CYCLES)
) chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .arrayProtect(arrayProtect),
  .writeBusy(writeBusy), .writeEnableLatch(writeEnableLatch),
  .registerWriteLatch(registerWriteLatch)
);
`default_nettype wire

/* File: serial_slave_pkg.sv */
// Purpose: Shared constants and types of the two-wire memory slave
// Assumes: 40 MHz system clock
// Notes:   Shared offsets, bus and address reset values and the write cycle count live here
package serial_slave_pkg;

  // ----------------------------------------------------------------
  // Bus framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] ARRAY_ID    = 4'ha;
  localparam logic [3:0] AREA_ID     = 4'hd;
  localparam logic [2:0] SELECT_BITS = 3'h7;
  localparam logic [6:0] ARRAY_SLAVE = {ARRAY_ID, SELECT_BITS};
  localparam logic [6:0] AREA_SLAVE  = {AREA_ID, SELECT_BITS};
  localparam logic [1:0] BUS_IDLE    = 2'h3;
  localparam logic [1:0] IDX_DATA    = 2'h3;

  // ----------------------------------------------------------------
  // Storage layout
  // ----------------------------------------------------------------
  localparam int          ARRAY_DEPTH = 512;
  localparam int          AREA_DEPTH  = 64;
  localparam int          PAGE_BYTES  = 64;
  localparam logic [6:0]  PAGE_END    = 7'h40;
  localparam logic [15:0] STATUS_ADDR = 16'h003f;
  localparam int          WR_EN_BIT   = 1;
  localparam int          REG_EN_BIT  = 2;
  localparam logic [15:0] ADDR_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_NS    = 25;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES  =
    (WRITE_TIME_MS * 1000000) / SYS_CLK_NS;

  // ----------------------------------------------------------------
  // Protocol states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_RXACK = 3'b010,
    ST_TX    = 3'b011,
    ST_TXACK = 3'b100
  } state_t;

endpackage

/* File: tb_top.sv */
// Purpose: Self-checking bench of the two-wire slave
// Assumes: Master model on the bus, SDA pulled up
// Notes:   Write cycle shortened by parameter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int WCYC = 300;
  localparam int LIMIT = 30000;
  logic sys_clk, rst_n, arrayProtect, scl, sdaPull;
  logic sdaOut, sdaOe, writeBusy, wrEn, regEn;
  wire logic sdaLine;
  int fails = 0;
  int checksDone = 0;
  int cycles = 0;
  // Pull-up: either party may pull low
  assign sdaLine = !(sdaPull || sdaOe);
  two_wire_master m (.sys_clk(sys_clk), .sdaLine(sdaLine),
    .scl(scl), .sdaPull(sdaPull));
  eeprom_rtc_serial_slave #(.WRITE_CYCLES(WCYC)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .arrayProtect(arrayProtect),
    .writeBusy(writeBusy), .writeEnableLatch(wrEn),
    .registerWriteLatch(regEn));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d fails %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    checksDone++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] flags();
    return {5'h00, writeBusy, regEn, wrEn};
  endfunction
  task automatic pulse_reset();
    @(posedge sys_clk) rst_n <= 1'b0;
    m.tick(6);
    rst_n <= 1'b1;
    m.tick(4);
  endtask
  task automatic send(input logic [7:0] q[$], output logic [7:0] a);
    logic k;
    a = 8'h00;
    m.start();
    foreach (q[i]) begin
      m.wbyte(q[i], k);
      a[i] = k;
    end
  endtask
  task automatic wr(input logic [7:0] q[$], input logic [7:0] e);
    logic [7:0] a;
    send(q, a);
    m.stop();
    chk("acks", e, a);
  endtask
  task automatic rd(input logic [7:0] s, input logic [7:0] e[$]);
    logic k;
    logic [7:0] d;
    m.start();
    m.wbyte(s, k);
    chk("read ack", 8'h01, {7'h00, k});
    foreach (e[i]) begin
      m.rbyte(i < e.size() - 1, d);
      chk("data", e[i], d);
    end
    m.stop();
  endtask
  task automatic rrd(input logic [7:0] s, input logic [15:0] ad,
                     input logic [7:0] e[$]);
    logic [7:0] a;
    send({s & 8'hfe, ad[15:8], ad[7:0]}, a);
    chk("addr acks", 8'h07, a);
    rd(s, e);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (writeBusy !== 1'b0 && n < WCYC + 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk("busy end", 8'h00, {7'h00, writeBusy});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_refuse();
    logic [7:0] slv [7];
    slv = '{8'hae, 8'hde, 8'ha0, 8'hac, 8'hbe, 8'h5e, 8'hee};
    for (int i = 0; i < 7; i++) begin
      wr({slv[i]}, (i < 2) ? 8'h01 : 8'h00);
    end
  endtask
  task automatic s_status();
    wr({8'hae, 8'h00, 8'h10, 8'h77}, 8'h07);
    chk("flags", 8'h00, flags());
    wr({8'hde, 8'h00, 8'h3f, 8'h02}, 8'h0f);
    chk("flags", 8'h01, flags());
    wr({8'hde, 8'h00, 8'h3f, 8'h06}, 8'h0f);
    chk("flags", 8'h03, flags());
    rrd(8'hdf, 16'h003f, {8'h06});
    wr({8'hde, 8'h00, 8'h3f, 8'h00, 8'h00}, 8'h0f);
    chk("flags", 8'h03, flags());
    wr({8'hde, 8'h00, 8'h3f, 8'h00}, 8'h0f);
    chk("flags", 8'h00, flags());
  endtask
  task automatic s_first();
    wr({8'hde, 8'h00, 8'h3f, 8'h02}, 8'h0f);
    wr({8'hae, 8'h00, 8'h00, 8'h5a, 8'ha5}, 8'h1f);
    chk("flags", 8'h05, flags());
    wait_done();
    wr({8'hae, 8'h01, 8'h00}, 8'h07);
    pulse_reset();
    chk("flags", 8'h00, flags());
    rd(8'haf, {8'h5a, 8'ha5});
  endtask
  task automatic s_page();
    logic [7:0] a;
    wr({8'hde, 8'h00, 8'h3f, 8'h02}, 8'h0f);
    wr({8'hae, 8'h01, 8'hfe, 8'hc1, 8'hc2, 8'hc3}, 8'h3f);
    send({8'hae}, a);
    m.stop();
    chk("poll busy", 8'h00, a);
    wait_done();
    wr({8'hae}, 8'h01);
    rrd(8'haf, 16'h01ff, {8'hc2, 8'h5a});
    rd(8'haf, {8'ha5});
    rrd(8'haf, 16'h01c0, {8'hc3});
    rrd(8'haf, 16'h01fe, {8'hc1});
  endtask
  task automatic s_guard();
    logic [7:0] a;
    logic r;
    @(posedge sys_clk) arrayProtect <= 1'b1;
    wr({8'hae, 8'h00, 8'h40, 8'h11}, 8'h0f);
    chk("flags", 8'h01, flags());
    wr({8'hae}, 8'h01);
    wr({8'hde, 8'h00, 8'h10, 8'h33}, 8'h0f);
    chk("flags", 8'h01, flags());
    @(posedge sys_clk) arrayProtect <= 1'b0;
    send({8'hae, 8'h00, 8'h30, 8'h55}, a);
    chk("acks", 8'h0f, a);
    for (int i = 0; i < 4; i++) m.cyc(1'b1, 1'b1, r);
    m.stop();
    chk("flags", 8'h01, flags());
    wr({8'hae, 8'h00, 8'h30}, 8'h07);
    chk("flags", 8'h01, flags());
    chk("sda drive", 8'h00, {7'h00, sdaOut});
  endtask
  initial begin
    rst_n = 1'b0;
    arrayProtect = 1'b0;
    pulse_reset();
    s_refuse();
    s_status();
    s_first();
    s_page();
    s_guard();
    close_out();
  end
endmodule
`default_nettype wire

/* File: two_wire_master.sv */
// Purpose: Bus master model driving SCL and pulling SDA
// Assumes: SCL period 8 clocks, low 5 and high 3
// Notes:   SCL stands high between frames
`timescale 1ns/1ps
`default_nettype none
module two_wire_master (
  // Clock
  input  wire logic sys_clk,
  // Bus
  input  wire logic sdaLine,
  output var  logic scl,
  output var  logic sdaPull
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // SDA moves mid-low so slave edges never meet it
  task automatic cyc(input logic o1, input logic o2, output logic r);
    @(posedge sys_clk) scl <= 1'b0;
    tick(3);
    sdaPull <= o1;
    tick(2);
    scl <= 1'b1;
    tick(1);
    @(negedge sys_clk) r = sdaLine;
    @(posedge sys_clk) sdaPull <= o2;
  endtask
  task automatic start();
    logic r;
    cyc(1'b0, 1'b1, r);
    tick(1);
  endtask
  task automatic stop();
    logic r;
    cyc(1'b1, 1'b0, r);
    tick(8);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) cyc(~d[i], ~d[i], r);
    cyc(1'b0, 1'b0, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      cyc(1'b0, 1'b0, r);
      d[i] = r;
    end
    cyc(ack, ack, r);
  endtask
endmodule
`default_nettype wire

/* File: two_wire_sync.sv */
// Purpose: Brings the bus pins into the system clock and finds edges
// Assumes: Pins idle high
// Notes:   Edges lag the pins by two system clocks
`timescale 1ns/1ps
`default_nettype none
module two_wire_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Raw pins
  input  wire logic scl,
  input  wire logic sdaIn,
  // Synchronised levels and edges
  output var  logic sclLvl,
  output var  logic sclPrev,
  output var  logic sdaLvl,
  output var  logic sclRise,
  output var  logic sclFall,
  output var  logic sdaRise,
  output var  logic sdaFall
);

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] prev_reg;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, then one history stage
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= serial_slave_pkg::BUS_IDLE;
      sync_reg <= serial_slave_pkg::BUS_IDLE;
      prev_reg <= serial_slave_pkg::BUS_IDLE;
    end else begin
      meta_reg <= {scl, sdaIn};
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  always_comb begin
    sclLvl  = sync_reg[1];
    sdaLvl  = sync_reg[0];
    sclPrev = prev_reg[1];
    sclRise = sync_reg[1] & ~prev_reg[1];
    sclFall = ~sync_reg[1] & prev_reg[1];
    sdaRise = sync_reg[0] & ~prev_reg[0];
    sdaFall = ~sync_reg[0] & prev_reg[0];
  end

endmodule
`default_nettype wire
